/* verilog/itfs_pkg.sv */
// Purpose: constants and types for the interrupt trigger and fifo status register bank
// Assumes: avalon-mm slave with 32-bit data, byte addresses
// Notes: one package shared by the design file and both testbench files
package itfs_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned SRC_N = 16;
   localparam int unsigned CNT_W = 20;
   localparam int unsigned DIV_W = 16;
   localparam logic [ADDR_W-1:0] OFS_ICTRL = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_TXDIV = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_TXDEPTH = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_RXDEPTH = 8'h44;
   localparam logic [ADDR_W-1:0] OFS_TXFILL = 8'h48;
   localparam logic [ADDR_W-1:0] OFS_RXFILL = 8'h4c;
   localparam logic [ADDR_W-1:0] OFS_ITYPE = 8'h50;
   localparam logic [ADDR_W-1:0] OFS_IPOL = 8'h54;
   localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h58;
   localparam logic [SRC_N-1:0] SRC_ZERO = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
   localparam logic [SRC_N-1:0] MASK_RESET = 16'hffff;
   localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      ITFS_IDLE = 2'b00,
      ITFS_ANSWER = 2'b01
   } itfs_bus_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } itfs_req_s;

   typedef struct packed {
      logic [CNT_W-1:0] tx_depth;
      logic [CNT_W-1:0] rx_depth;
      logic [CNT_W-1:0] tx_fill;
      logic [CNT_W-1:0] rx_fill;
   } itfs_fifo_s;
endpackage

/* verilog/itfs_regs.sv */
// Purpose: interrupt trigger, status latch, tx clock divider and fifo status registers
// Assumes: sources and fifo counts come from logic on clk; avalon-mm slave, one wait state
// Notes: live sources pass straight to detection, no synchroniser needed
// Function
// RULE1: enabled source event is latched in status until software writes one there
// RULE2: disabled source shows live state in status and never raises interrupt
// RULE3: status holds sixteen source bits in 15..0, upper bits read zero
// RULE4: tx clock is onboard clock divided by 16-bit value in divider bits 15..0
// RULE5: divide value zero or one passes clock undivided
// RULE6: tx depth register reports 20-bit depth captured once after power-up
// RULE7: rx depth register reports 20-bit depth captured once after power-up
// RULE8: tx fill register tracks current tx fifo word count in bits 19..0
// RULE9: rx fill register tracks current rx fifo word count in bits 19..0
// RULE10: trigger type bit one means edge, zero means level
// RULE11: polarity bit one means rising or high, zero falling or low
// RULE12: sixteen sources each enabled by matching interrupt control bit
// RULE13: interrupt request high while a latched enabled status bit stays set; code also needs the matching mask bit set
// RULE14: reset clears divider, type, polarity and latched status
module itfs_regs
   import itfs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [SRC_N-1:0] irq_src,
   input wire itfs_fifo_s fifo_info,
   output logic tx_clk_en,
   output logic irq
);
   itfs_req_s req;
   itfs_bus_e bus_q;
   logic [SRC_N-1:0] ctrl_q, type_q, pol_q, mask_q, stat_q, src_q, event_w, clr_w;
   logic [DIV_W-1:0] div_q, divcnt_q;
   logic [CNT_W-1:0] txd_q, rxd_q, txf_q, rxf_q;
   logic depth_done_q;
   logic wr_acc, rd_acc;
   logic [31:0] rd_d;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] zx16(input logic [SRC_N-1:0] v);
      return {16'h0000, v};
   endfunction

   assign req = '{read: read, write: write, address: address, writedata: writedata,
                  byteenable: byteenable};
   // one wait state: answer lands in the cycle after the request appears
   assign waitrequest = (req.read || req.write) && (bus_q == ITFS_IDLE);
   assign wr_acc = req.write && (bus_q == ITFS_ANSWER);
   assign rd_acc = req.read && (bus_q == ITFS_ANSWER);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_q <= ITFS_IDLE;
      end else begin
         case (bus_q)
            ITFS_IDLE: begin
               if (req.read || req.write) begin
                  bus_q <= ITFS_ANSWER;
               end
            end
            ITFS_ANSWER: bus_q <= ITFS_IDLE;
            default: bus_q <= ITFS_IDLE;
         endcase
      end
   end

   // control registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= SRC_ZERO;
         type_q <= SRC_ZERO; // [RULE14]
         pol_q <= SRC_ZERO; // [RULE14]
         div_q <= DIV_RESET; // [RULE14]
         mask_q <= MASK_RESET;
      end else if (wr_acc) begin
         case (req.address)
            OFS_ICTRL: ctrl_q <= wmerge(zx16(ctrl_q), req.writedata, req.byteenable)
               [SRC_N-1:0]; // [RULE12]
            OFS_ITYPE: type_q <= wmerge(zx16(type_q), req.writedata, req.byteenable)
               [SRC_N-1:0];
            OFS_IPOL: pol_q <= wmerge(zx16(pol_q), req.writedata, req.byteenable)
               [SRC_N-1:0];
            OFS_IMASK: mask_q <= wmerge(zx16(mask_q), req.writedata, req.byteenable)
               [SRC_N-1:0];
            OFS_TXDIV: div_q <= wmerge({16'h0000, div_q}, req.writedata, req.byteenable)
               [DIV_W-1:0]; // [RULE4]
            default: ;
         endcase
      end
   end

   // trigger detection: active level after polarity, edge compares with last sample
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_q <= SRC_ZERO;
      end else begin
         src_q <= irq_src;
      end
   end

   always_comb begin
      for (int i = 0; i < SRC_N; i++) begin
         if (type_q[i]) begin
            // [RULE10] [RULE11]
            event_w[i] = pol_q[i] ? (irq_src[i] && !src_q[i]) : (!irq_src[i] && src_q[i]);
         end else begin
            event_w[i] = pol_q[i] ? irq_src[i] : !irq_src[i];
         end
      end
   end

   assign clr_w = (wr_acc && req.address == OFS_ISTAT && req.byteenable[0] &&
                   req.byteenable[1]) ? req.writedata[SRC_N-1:0] :
                  (wr_acc && req.address == OFS_ISTAT) ?
                  {req.byteenable[1] ? req.writedata[15:8] : 8'h00,
                   req.byteenable[0] ? req.writedata[7:0] : 8'h00} : SRC_ZERO;

   // set wins over the write-one clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_q <= SRC_ZERO; // [RULE14]
      end else begin
         for (int i = 0; i < SRC_N; i++) begin
            if (ctrl_q[i]) begin
               stat_q[i] <= event_w[i] | (stat_q[i] & ~clr_w[i]); // [RULE1]
            end else begin
               stat_q[i] <= 1'b0;
            end
         end
      end
   end

   // disabled bits read the live source state, not the latch
   assign irq = |(stat_q & ctrl_q & mask_q); // [RULE13] [RULE2]

   // divider: enable every div_q-th cycle, every cycle for 0 or 1
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divcnt_q <= DIV_RESET;
         tx_clk_en <= 1'b0;
      end else if (div_q <= DIV_ONE) begin
         divcnt_q <= DIV_RESET;
         tx_clk_en <= 1'b1; // [RULE5]
      end else if (divcnt_q >= div_q - DIV_ONE) begin
         divcnt_q <= DIV_RESET;
         tx_clk_en <= 1'b1; // [RULE4]
      end else begin
         divcnt_q <= divcnt_q + DIV_ONE;
         tx_clk_en <= 1'b0;
      end
   end

   // depths are caught once after each reset release, fill counts track always
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         depth_done_q <= 1'b0;
         txd_q <= '0;
         rxd_q <= '0;
         txf_q <= '0;
         rxf_q <= '0;
      end else begin
         if (!depth_done_q) begin
            txd_q <= fifo_info.tx_depth; // [RULE6]
            rxd_q <= fifo_info.rx_depth; // [RULE7]
            depth_done_q <= 1'b1;
         end
         txf_q <= fifo_info.tx_fill; // [RULE8]
         rxf_q <= fifo_info.rx_fill; // [RULE9]
      end
   end

   always_comb begin
      case (req.address)
         OFS_ICTRL: rd_d = zx16(ctrl_q);
         OFS_ISTAT: rd_d = zx16((stat_q & ctrl_q) | (irq_src & ~ctrl_q)); // [RULE3] [RULE2]
         OFS_TXDIV: rd_d = {16'h0000, div_q};
         OFS_TXDEPTH: rd_d = {12'h000, txd_q};
         OFS_RXDEPTH: rd_d = {12'h000, rxd_q};
         OFS_TXFILL: rd_d = {12'h000, txf_q};
         OFS_RXFILL: rd_d = {12'h000, rxf_q};
         OFS_ITYPE: rd_d = zx16(type_q);
         OFS_IPOL: rd_d = zx16(pol_q);
         OFS_IMASK: rd_d = zx16(mask_q);
         default: rd_d = UNMAPPED_RDATA;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata <= UNMAPPED_RDATA;
      end else if (req.read && bus_q == ITFS_IDLE) begin
         readdata <= rd_d;
      end
   end

   a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_q[0] && stat_q[0] && !clr_w[0] && !(wr_acc && req.address == OFS_ICTRL)
      |=> stat_q[0]) // [RULE1]
      else $error("latched status bit lost without clear");
   a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_q == SRC_ZERO |-> !irq) // [RULE2]
      else $error("disabled sources raised interrupt");
   // irq may only rise after an enabled event or after the mask opens
   a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
      $past(rst_n) && $rose(irq) |->
      $past(|(event_w & ctrl_q)) || $past(wr_acc && req.address == OFS_IMASK))
      else $error("interrupt rose without a cause");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rd_acc && (req.address == OFS_ISTAT) |-> readdata[31:16] == 16'h0000) // [RULE3]
      else $error("status reserved bits not zero");
   a_div_bypass: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) && (div_q <= DIV_ONE) && $past(div_q <= DIV_ONE) |-> tx_clk_en) // [RULE5]
      else $error("undivided clock enable dropped");
   a_div_period: assert property (@(posedge clk) disable iff (!rst_n)
      (div_q == 16'h0003) && $stable(div_q) && tx_clk_en ##1 $stable(div_q)
      |-> !tx_clk_en ##1 (!tx_clk_en || div_q != 16'h0003)) // [RULE4]
      else $error("divide by three spacing wrong");
   a_depth_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      depth_done_q && $past(depth_done_q) |-> $stable(txd_q) && $stable(rxd_q)) // [RULE6]
      else $error("fifo depth changed after capture");
   a_fill_tracks: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> txf_q == $past(fifo_info.tx_fill)) // [RULE8]
      else $error("fill count does not track");
   a_rx_fill_tracks: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
      $past(rst_n) |-> rxf_q == $past(fifo_info.rx_fill))
      else $error("rx fill count does not track");
   a_rx_depth_fixed: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
      depth_done_q && $past(depth_done_q) |-> $stable(rxd_q))
      else $error("rx fifo depth changed after capture");
   a_level_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
      !type_q[4] && !pol_q[4] && !irq_src[4] |-> event_w[4])
      else $error("active-low level not detected");
   a_w1c_clears: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
      ctrl_q[5] && clr_w[5] && !event_w[5] |=> !stat_q[5])
      else $error("write one did not clear status");
   a_disabled_unlatched: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
      !ctrl_q[6] |=> !stat_q[6])
      else $error("disabled source latched");
   a_edge_once: assert property (@(posedge clk) disable iff (!rst_n)
      type_q[2] && pol_q[2] && !irq_src[2] && $past(type_q[2]) |-> !event_w[2]) // [RULE10]
      else $error("edge source fired on low level");
   a_reset_clear: assert property (@(posedge clk)
      !rst_n |=> stat_q == SRC_ZERO && div_q == DIV_RESET && type_q == SRC_ZERO) // [RULE14]
      else $error("reset left state behind");

   c_irq_set: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
   c_w1c: cover property (@(posedge clk) disable iff (!rst_n) $fell(irq));
   c_div_run: cover property (@(posedge clk) disable iff (!rst_n)
      div_q > DIV_ONE && tx_clk_en);
   c_read_ans: cover property (@(posedge clk) disable iff (!rst_n) rd_acc);
   c_edge_hit: cover property (@(posedge clk) disable iff (!rst_n)
      |(event_w & ctrl_q & type_q));
endmodule

/* tb/itfs_host.sv */
// Purpose: avalon-mm host model standing in for the bridge local bus
// Assumes: one request at a time, slave ends each by waitrequest low
// Notes: released address and data lines show inverted values, not the last ones
module itfs_host
   import itfs_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   output logic hung
);
   initial begin
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = '0;
      byteenable = 4'hf;
      hung = 1'b0;
   end

   // bounded wait: a slave that never answers raises hung instead of stalling the run
   task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= rd;
      write <= ~rd;
      n = 0;
      // look at waitrequest mid-cycle, where it has settled, then take the answer edge
      do begin
         @(negedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 16);
      @(posedge clk);
      if (n >= 16) hung <= 1'b1;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      address <= ~a;
      writedata <= ~d;
   endtask
endmodule

/* tb/itfs_regs_test.sv */
// Purpose: self-checking bench for the interrupt trigger and fifo status registers
// Assumes: 20 mhz clock, synchronous active-low reset held 3 cycles
// Notes: sources change only right after an edge, so detection sees clean samples
module itfs_regs_test
   import itfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, read, write, waitrequest, tx_clk_en, irq, hung;
   logic [ADDR_W-1:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [SRC_N-1:0] irq_src;
   itfs_fifo_s fifo_info;
   int bad_count = 0;
   int num_checks = 0;

   itfs_regs dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .irq_src(irq_src),
      .fifo_info(fifo_info), .tx_clk_en(tx_clk_en), .irq(irq));
   itfs_host host (.clk(clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .hung(hung));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b0, a, d, q);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] q;
      host.xfer(1'b1, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic t_reset();
      fifo_info.tx_depth <= 20'h00777;
      rdchk(OFS_TXDIV, 32'h0);
      rdchk(OFS_ITYPE, 32'h0);
      rdchk(OFS_IPOL, 32'h0);
      rdchk(OFS_TXDEPTH, 32'h400);
      rdchk(OFS_RXDEPTH, 32'h800);
      rdchk(8'h60, UNMAPPED_RDATA);
      fifo_info.tx_fill <= 20'hfffff;
      fifo_info.rx_fill <= 20'h00001;
      rdchk(OFS_TXFILL, 32'hfffff);
      rdchk(OFS_RXFILL, 32'h1);
   endtask

   // upper half of a divider write is reserved, so 0x10000 must act as zero
   task automatic t_div();
      logic [31:0] dv[4] = '{32'h0, 32'h1, 32'h10000, 32'hffff0003};
      int ex[4] = '{12, 12, 12, 4};
      int c;
      foreach (dv[k]) begin
         wr(OFS_TXDIV, dv[k]);
         repeat (4) @(posedge clk);
         c = 0;
         repeat (12) begin
            @(posedge clk);
            if (tx_clk_en === 1'b1) c++;
         end
         chk(c, ex[k]);
         rdchk(OFS_TXDIV, dv[k] & 32'hffff);
      end
   endtask

   task automatic t_level();
      wr(OFS_IPOL, 32'hffff);
      wr(OFS_ICTRL, 32'hffff);
      for (int i = 0; i < SRC_N; i++) begin
         irq_src <= 16'h1 << i;
         repeat (2) @(posedge clk);
         chk({31'h0, irq}, 32'h1);
         irq_src <= SRC_ZERO;
         rdchk(OFS_ISTAT, 32'h1 << i);
         wr(OFS_ISTAT, 32'h1 << i);
         @(posedge clk);
         chk({31'h0, irq}, 32'h0);
      end
      wr(OFS_IMASK, 32'h0);
      irq_src <= 16'h0008;
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      irq_src <= SRC_ZERO;
      wr(OFS_IMASK, 32'hffff);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_ISTAT, 32'h8);
   endtask

   task automatic t_edge();
      wr(OFS_ITYPE, 32'h6);
      wr(OFS_IPOL, 32'hfffd);
      irq_src <= 16'h0006;
      repeat (2) @(posedge clk);
      rdchk(OFS_ISTAT, 32'h4);
      wr(OFS_ISTAT, 32'h4);
      rdchk(OFS_ISTAT, 32'h0);
      irq_src <= SRC_ZERO;
      repeat (2) @(posedge clk);
      rdchk(OFS_ISTAT, 32'h2);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(OFS_ISTAT, 32'h0);
      rdchk(OFS_ITYPE, 32'h0);
   endtask

   task automatic t_dis();
      irq_src <= 16'h8020;
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(OFS_ISTAT, 32'h8020);
   endtask

   always @(posedge hung) begin
      bad_count++;
      final_report();
   end

   initial begin
      rst_n = 1'b0;
      irq_src = SRC_ZERO;
      fifo_info = '{tx_depth: 20'h400, rx_depth: 20'h800, tx_fill: '0, rx_fill: '0};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_div();
      t_level();
      t_edge();
      t_dis();
      final_report();
   end
endmodule
